//--- nepu_map.svh
// register offsets, field positions and reset values of the node event unit
// assumes word-addressed 8-bit register index over the plain register port
`ifndef NEPU_MAP_SVH
`define NEPU_MAP_SVH
`define NEPU_A_BOUND      8'h00
`define NEPU_A_TIMER      8'h01
`define NEPU_A_TIMEOUT    8'h02
`define NEPU_A_TMR_VEC    8'h03
`define NEPU_A_DEP_VEC    8'h04
`define NEPU_A_CTRL       8'h05
`define NEPU_A_STATUS     8'h06
`define NEPU_A_CLEAR      8'h07
`define NEPU_A_ENABLE     8'h08
`define NEPU_A_PROF       8'h09
`define NEPU_A_NODE_ADDR  8'h0A
`define NEPU_A_ERRS       8'h0B
`define NEPU_A_DBG_VEC    8'h0C
`define NEPU_CTRL_AM      0
`define NEPU_CTRL_BOOTX   1
`define NEPU_ST_ARR       0
`define NEPU_ST_DEP       1
`define NEPU_ST_TMR       2
`define NEPU_ST_PROT      3
`define NEPU_ST_DBG       4
`define NEPU_ST_W         5
`define NEPU_BOUND_RST    32'h0000_1000
`define NEPU_TOUT_RST     32'hFFFF_FFFF
`define NEPU_DBG_VEC_RST  32'h0000_0100
`endif

//--- nepu_pkg.sv
// types shared by the node event unit
// assumes nepu_map.svh for constants
package nepu_pkg;
  typedef enum logic [2:0] {
    NEPU_EV_NONE = 3'h0,
    NEPU_EV_DBG  = 3'h1,
    NEPU_EV_PROT = 3'h2,
    NEPU_EV_ARR  = 3'h3,
    NEPU_EV_TMR  = 3'h4,
    NEPU_EV_DEP  = 3'h5
  } nepu_ev_t;
endpackage

//--- nepu_unit.sv
// event, protection and bootstrap logic of one mesh node
// assumes cpu, network and scan network share the one clock; scan pins are synchronised here
`timescale 1ns/1ps
`include "nepu_map.svh"
module nepu_unit #(
  parameter int AW = 32,
  parameter int IC_DEPTH = 256
) (
  // clock, reset, enable
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          clk_en,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // cpu access check
  input  wire logic          cpu_acc,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic          cpu_kernel,
  output logic               acc_grant,
  output logic               acc_fault,
  // cpu event vectoring
  input  wire logic          cpu_can_take,
  input  wire logic [AW-1:0] cpu_pc,
  output logic               ev_take,
  output logic      [AW-1:0] ev_vector,
  output logic      [2:0]    ev_cause,
  // network
  input  wire logic          net_rx_new,
  input  wire logic [31:0]   net_rx_word0,
  input  wire logic          net_tx_room,
  input  wire logic [7:0]    net_buf_stat,
  input  wire logic [7:0]    mem_buf_stat,
  input  wire logic          mem_par_err,
  input  wire logic          msg_par_err,
  input  wire logic [15:0]   node_addr_strap,
  // bootstrap state
  output logic               boot_mode,
  output logic               cache_locked,
  output logic               periph_mode,
  output logic      [15:0]   node_addr,
  // host scan network pins
  input  wire logic          scan_ic_wr,
  input  wire logic [7:0]    scan_ic_addr,
  input  wire logic [31:0]   scan_ic_data,
  input  wire logic          scan_dbg,
  input  wire logic          scan_cap,
  output logic      [87:0]   scan_view,
  output logic      [31:0]   icache_rdata,
  input  wire logic [7:0]    icache_raddr,
  // interrupt
  output logic               irq
);
  if (AW < 16 || AW > 32) begin : g_bad_aw
    $error("AW out of range");
  end
  if (IC_DEPTH < 2 || IC_DEPTH > 256) begin : g_bad_depth
    $error("IC_DEPTH out of range");
  end

  logic [AW-1:0] bound_r, tmr_vec_r, dep_vec_r, dbg_vec_r;
  logic [31:0]   timer_r, timeout_r, prof_r, icache_rdata_r;
  logic [1:0]    ctrl_r;
  logic [`NEPU_ST_W-1:0] status_r, enable_r, status_nxt, ev_set;
  logic          pend_arr_r, pend_dep_r, pend_tmr_r, pend_dbg_r;
  logic [31:0]   arr_vec_r;
  logic          mem_err_r, msg_err_r, boot_r;
  logic [15:0]   node_addr_r;
  logic          strap_ld_r;
  logic [31:0]   ic_mem [IC_DEPTH];
  // scan pin synchronisers
  logic [41:0]   sc_s1_r, sc_s2_r;
  logic          sc_dbg_d_r, sc_wr_d_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      sc_s1_r <= 42'h0;
      sc_s2_r <= 42'h0;
    end else if (clk_en) begin
      sc_s1_r <= {scan_cap, scan_dbg, scan_ic_wr, scan_ic_addr, scan_ic_data[30:0]};
      sc_s2_r <= sc_s1_r;
    end
  end

  // data bit 31 rides its own pair, so the word is split across two bundles
  logic sd31_s1_r, sd31_s2_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      sd31_s1_r <= 1'b0;
      sd31_s2_r <= 1'b0;
    end else if (clk_en) begin
      sd31_s1_r <= scan_ic_data[31];
      sd31_s2_r <= sd31_s1_r;
    end
  end

  wire        sc_cap   = sc_s2_r[41];
  wire        sc_dbg   = sc_s2_r[40];
  wire        sc_wr    = sc_s2_r[39];
  wire [7:0]  sc_iaddr = sc_s2_r[38:31];
  wire [31:0] sc_idata = {sd31_s2_r, sc_s2_r[30:0]};
  // host holds data steady around the write edge, so the rising edge samples settled bits
  wire        sc_wr_p  = sc_wr & ~sc_wr_d_r;
  wire        sc_dbg_p = sc_dbg & ~sc_dbg_d_r;

  // register decode
  wire wr_bound = reg_wr && reg_addr == `NEPU_A_BOUND;
  wire wr_tout  = reg_wr && reg_addr == `NEPU_A_TIMEOUT;
  wire wr_tvec  = reg_wr && reg_addr == `NEPU_A_TMR_VEC;
  wire wr_dvec  = reg_wr && reg_addr == `NEPU_A_DEP_VEC;
  wire wr_ctrl  = reg_wr && reg_addr == `NEPU_A_CTRL;
  wire wr_clr   = reg_wr && reg_addr == `NEPU_A_CLEAR;
  wire wr_en    = reg_wr && reg_addr == `NEPU_A_ENABLE;
  wire wr_prof  = reg_wr && reg_addr == `NEPU_A_PROF;
  wire wr_gvec  = reg_wr && reg_addr == `NEPU_A_DBG_VEC;

  // protection check
  wire below_bound = cpu_addr < bound_r;
  wire prot_fault  = cpu_acc && !cpu_kernel && below_bound;

  // event sources
  wire tmr_hit = timer_r == timeout_r;
  wire arr_ev  = net_rx_new && ctrl_r[`NEPU_CTRL_AM];
  wire dep_ev  = net_tx_room && !boot_r;

  // fixed priority: debug, arrival, timer, departure; faults only flag status
  wire take_dbg = pend_dbg_r;
  wire take_arr = !take_dbg && pend_arr_r;
  wire take_tmr = !take_dbg && !pend_arr_r && pend_tmr_r;
  wire take_dep = !take_dbg && !pend_arr_r && !pend_tmr_r && pend_dep_r;
  wire any_take = cpu_can_take && (take_dbg || take_arr || take_tmr || take_dep);
  wire [AW-1:0] vec_sel = take_dbg ? dbg_vec_r :
                          take_arr ? arr_vec_r[AW-1:0] :
                          take_tmr ? tmr_vec_r : dep_vec_r;
  wire [2:0] cause_sel = take_dbg ? nepu_pkg::NEPU_EV_DBG :
                         take_arr ? nepu_pkg::NEPU_EV_ARR :
                         take_tmr ? nepu_pkg::NEPU_EV_TMR : nepu_pkg::NEPU_EV_DEP;

  assign ev_set = {sc_dbg_p, prot_fault, tmr_hit, dep_ev, arr_ev};
  // set wins over clear
  assign status_nxt = (status_r & ~(wr_clr ? reg_wdata[`NEPU_ST_W-1:0] : 5'h00)) | ev_set;

  always_ff @(posedge clock) begin
    if (srst) begin
      bound_r   <= AW'(`NEPU_BOUND_RST);
      timeout_r <= `NEPU_TOUT_RST;
      tmr_vec_r <= '0;
      dep_vec_r <= '0;
      dbg_vec_r <= AW'(`NEPU_DBG_VEC_RST);
      ctrl_r    <= 2'h0;
      enable_r  <= 5'h00;
      status_r  <= 5'h00;
      prof_r    <= 32'h0;
    end else if (clk_en) begin
      if (wr_bound) bound_r <= reg_wdata[AW-1:0];
      if (wr_tout)  timeout_r <= reg_wdata;
      if (wr_tvec)  tmr_vec_r <= reg_wdata[AW-1:0];
      if (wr_dvec)  dep_vec_r <= reg_wdata[AW-1:0];
      if (wr_gvec)  dbg_vec_r <= reg_wdata[AW-1:0];
      if (wr_ctrl)  ctrl_r <= reg_wdata[1:0];
      if (wr_en)    enable_r <= reg_wdata[`NEPU_ST_W-1:0];
      if (wr_prof)  prof_r <= reg_wdata;
      status_r <= status_nxt;
    end
  end

  // free-running timer
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_r <= 32'h0;
    end else if (clk_en) begin
      timer_r <= timer_r + 32'h1;
    end
  end

  // pending events held until the handler is entered
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_arr_r <= 1'b0;
      pend_dep_r <= 1'b0;
      pend_tmr_r <= 1'b0;
      pend_dbg_r <= 1'b0;
      arr_vec_r  <= 32'h0;
    end else if (clk_en) begin
      pend_arr_r <= arr_ev | (pend_arr_r & ~(any_take & take_arr));
      pend_tmr_r <= tmr_hit | (pend_tmr_r & ~(any_take & take_tmr));
      pend_dep_r <= dep_ev | (pend_dep_r & ~(any_take & take_dep));
      pend_dbg_r <= sc_dbg_p | (pend_dbg_r & ~(any_take & take_dbg));
      if (arr_ev) arr_vec_r <= net_rx_word0;
    end
  end

  // event and access outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      ev_take   <= 1'b0;
      ev_vector <= '0;
      ev_cause  <= nepu_pkg::NEPU_EV_NONE;
      acc_grant <= 1'b0;
      acc_fault <= 1'b0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      ev_take   <= any_take;
      ev_vector <= any_take ? vec_sel : ev_vector;
      ev_cause  <= any_take ? cause_sel : nepu_pkg::NEPU_EV_NONE;
      acc_grant <= cpu_acc && !prot_fault;
      acc_fault <= prot_fault;
      irq       <= |(status_nxt & enable_r);
    end
  end

  // bootstrap state, node address, error flags
  always_ff @(posedge clock) begin
    if (srst) begin
      boot_r      <= 1'b1;
      strap_ld_r  <= 1'b1;
      node_addr_r <= 16'h0;
      mem_err_r   <= 1'b0;
      msg_err_r   <= 1'b0;
      sc_dbg_d_r  <= 1'b0;
      sc_wr_d_r   <= 1'b0;
    end else if (clk_en) begin
      strap_ld_r <= 1'b0;
      if (strap_ld_r) node_addr_r <= node_addr_strap;
      if (wr_ctrl && reg_wdata[`NEPU_CTRL_BOOTX]) boot_r <= 1'b0;
      mem_err_r  <= mem_err_r | mem_par_err;
      msg_err_r  <= msg_err_r | msg_par_err;
      sc_dbg_d_r <= sc_dbg;
      sc_wr_d_r  <= sc_wr;
    end
  end

  assign boot_mode    = boot_r;
  assign cache_locked = boot_r;
  assign periph_mode  = boot_r;
  assign node_addr    = node_addr_r;

  // instruction cache loaded by the host in bootstrap
  always_ff @(posedge clock) begin
    if (clk_en && sc_wr_p && boot_r) begin
      ic_mem[sc_iaddr] <= sc_idata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      icache_rdata_r <= 32'h0;
    end else if (clk_en) begin
      icache_rdata_r <= ic_mem[icache_raddr];
    end
  end
  assign icache_rdata = icache_rdata_r;

  // run-time scan view, captured on request without stopping the cpu
  logic [87:0] scan_view_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      scan_view_r <= 88'h0;
    end else if (clk_en && sc_cap) begin
      scan_view_r <= {6'h0, mem_err_r, msg_err_r, net_buf_stat, mem_buf_stat,
                      32'(cpu_pc), prof_r};
    end
  end
  assign scan_view = scan_view_r;

  // read mux
  logic [31:0] rd_mux;
  assign rd_mux = (reg_addr == `NEPU_A_BOUND)     ? 32'(bound_r) :
                  (reg_addr == `NEPU_A_TIMER)     ? timer_r :
                  (reg_addr == `NEPU_A_TIMEOUT)   ? timeout_r :
                  (reg_addr == `NEPU_A_TMR_VEC)   ? 32'(tmr_vec_r) :
                  (reg_addr == `NEPU_A_DEP_VEC)   ? 32'(dep_vec_r) :
                  (reg_addr == `NEPU_A_CTRL)      ? {30'h0, ~boot_r, ctrl_r[0]} :
                  (reg_addr == `NEPU_A_STATUS)    ? {27'h0, status_r} :
                  (reg_addr == `NEPU_A_ENABLE)    ? {27'h0, enable_r} :
                  (reg_addr == `NEPU_A_PROF)      ? prof_r :
                  (reg_addr == `NEPU_A_NODE_ADDR) ? {16'h0, node_addr_r} :
                  (reg_addr == `NEPU_A_ERRS)      ? {30'h0, msg_err_r, mem_err_r} :
                  (reg_addr == `NEPU_A_DBG_VEC)   ? 32'(dbg_vec_r) : 32'h0;
  logic [31:0] reg_rdata_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata_r <= 32'h0;
    end else if (clk_en) begin
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // assertions
  sequence s_user_low;
    cpu_acc && !cpu_kernel && (cpu_addr < bound_r);
  endsequence
  prot_fault_a: assert property (@(posedge clock) disable iff (srst)
    (clk_en and s_user_low) |=> acc_fault && !acc_grant)
    else $error("user access below boundary not faulted");
  kern_grant_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && cpu_acc && cpu_kernel |=> acc_grant)
    else $error("kernel access refused");
  tmr_pend_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && timer_r == timeout_r |=> pend_tmr_r)
    else $error("timer match not pending");
  tmr_vec_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && any_take && take_tmr |=> ev_take && ev_vector == $past(tmr_vec_r))
    else $error("timer vector wrong");
  dep_vec_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && any_take && take_dep |=> ev_vector == $past(dep_vec_r))
    else $error("departure vector wrong");
  arr_vec_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && any_take && take_arr |=> ev_vector == $past(arr_vec_r[AW-1:0]))
    else $error("arrival vector wrong");
  pend_keep_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && pend_dep_r && !any_take |=> pend_dep_r)
    else $error("pending event lost");
  boot_rst_a: assert property (@(posedge clock)
    srst |=> boot_mode && cache_locked && periph_mode)
    else $error("not in bootstrap after reset");
  err_clr_a: assert property (@(posedge clock)
    srst |=> !mem_err_r && !msg_err_r)
    else $error("error flags not cleared");
  dbg_take_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && pend_dbg_r && cpu_can_take |=> ev_cause == nepu_pkg::NEPU_EV_DBG)
    else $error("debug entry not taken first");
  sequence s_take_dbg;
    clk_en && any_take && take_dbg;
  endsequence
  dbg_vec_a: assert property (@(posedge clock) disable iff (srst)
    s_take_dbg |=> ev_take && ev_vector == $past(dbg_vec_r))
    else $error("debug vector wrong");
  dbg_pend_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && sc_dbg_p |=> pend_dbg_r)
    else $error("debug request not pending");
  arr_pend_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && net_rx_new && ctrl_r[`NEPU_CTRL_AM] |=> pend_arr_r)
    else $error("arrival not pending");
  dep_pend_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && net_tx_room && !boot_r |=> pend_dep_r)
    else $error("departure not pending");
  user_grant_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && cpu_acc && !cpu_kernel && !below_bound |=> acc_grant && !acc_fault)
    else $error("user access above boundary refused");
  prot_status_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && prot_fault |=> status_r[`NEPU_ST_PROT])
    else $error("protection fault not flagged");
  node_load_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && strap_ld_r |=> node_addr == $past(node_addr_strap))
    else $error("node address not loaded");
  boot_keep_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && boot_r && !(wr_ctrl && reg_wdata[`NEPU_CTRL_BOOTX]) |=> boot_r)
    else $error("bootstrap state left without request");
  ev_cause_a: assert property (@(posedge clock) disable iff (srst)
    ev_take |-> ev_cause != nepu_pkg::NEPU_EV_NONE)
    else $error("event taken without cause");
  arr_prio_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && cpu_can_take && pend_arr_r && !pend_dbg_r |=> ev_cause == nepu_pkg::NEPU_EV_ARR)
    else $error("arrival not taken before timer or departure");
  err_stick_a: assert property (@(posedge clock) disable iff (srst)
    clk_en && (mem_par_err || mem_err_r) |=> mem_err_r)
    else $error("memory parity flag lost");
endmodule

//--- nepu_far_model.sv
// far side model: neighbour nodes on the mesh and the host scan network
// assumes one shared clock; the bench calls its tasks from its own thread
`timescale 1ns/1ps
module nepu_far_model (
  // clock
  input  wire logic        clock,
  // mesh network
  output logic             net_rx_new,
  output logic      [31:0] net_rx_word0,
  output logic             net_tx_room,
  output logic             mem_par_err,
  output logic             msg_par_err,
  // host scan network
  output logic             scan_ic_wr,
  output logic      [7:0]  scan_ic_addr,
  output logic      [31:0] scan_ic_data,
  output logic             scan_dbg
);
  initial begin
    net_rx_new = 1'b0;
    net_rx_word0 = 32'h0;
    net_tx_room = 1'b0;
    mem_par_err = 1'b0;
    msg_par_err = 1'b0;
    scan_ic_wr = 1'b0;
    scan_ic_addr = 8'h0;
    scan_ic_data = 32'h0;
    scan_dbg = 1'b0;
  end
  // first word carries the handler address; released word shows its inverse
  task automatic send_msg(input logic [31:0] w);
    @(posedge clock);
    net_rx_new <= 1'b1;
    net_rx_word0 <= w;
    @(posedge clock);
    net_rx_new <= 1'b0;
    net_rx_word0 <= ~w;
  endtask
  // scan pins are slow: held long enough for the two-stage synchroniser
  task automatic ic_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    scan_ic_addr <= a;
    scan_ic_data <= d;
    repeat (4) @(posedge clock);
    scan_ic_wr <= 1'b1;
    repeat (4) @(posedge clock);
    scan_ic_wr <= 1'b0;
    repeat (4) @(posedge clock);
    scan_ic_data <= ~d;
    scan_ic_addr <= ~a;
  endtask
  task automatic force_dbg;
    @(posedge clock);
    scan_dbg <= 1'b1;
    repeat (4) @(posedge clock);
    scan_dbg <= 1'b0;
  endtask
  task automatic par_err;
    @(posedge clock);
    mem_par_err <= 1'b1;
    msg_par_err <= 1'b1;
    @(posedge clock);
    mem_par_err <= 1'b0;
    msg_par_err <= 1'b0;
  endtask
  task automatic set_room(input logic r);
    @(posedge clock);
    net_tx_room <= r;
  endtask
endmodule

//--- node_event_protection_unit_test.sv
// self-checking bench of the node event unit
// assumes nepu_unit, nepu_map.svh and the far side model
`timescale 1ns/1ps
`include "nepu_map.svh"
module node_event_protection_unit_test;
  logic        clock, srst, reg_wr, reg_rd, cpu_acc, cpu_kernel, cpu_can_take, scan_cap;
  logic [7:0]  reg_addr, net_buf_stat, mem_buf_stat, icache_raddr, ia;
  logic [31:0] reg_wdata, cpu_addr, cpu_pc, reg_rdata, ev_vector, rnd, d, bnd, v;
  logic [15:0] strap, node_addr;
  logic [87:0] scan_view;
  logic [31:0] icache_rdata, w0;
  logic [2:0]  ev_cause;
  logic        acc_grant, acc_fault, ev_take, boot_mode, cache_locked, periph_mode, irq;
  logic        rx_new, tx_room, m_err, g_err, ic_wr, dbg, clk_en, pf;
  logic [7:0]  ic_addr;
  logic [31:0] rx_w0, ic_data, t;
  int          err_count, n_tests, cyc;

  nepu_unit u_dut (.clock(clock), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_acc(cpu_acc), .cpu_addr(cpu_addr), .cpu_kernel(cpu_kernel), .acc_grant(acc_grant),
    .acc_fault(acc_fault), .cpu_can_take(cpu_can_take), .cpu_pc(cpu_pc), .ev_take(ev_take),
    .ev_vector(ev_vector), .ev_cause(ev_cause), .net_rx_new(rx_new), .net_rx_word0(rx_w0),
    .net_tx_room(tx_room), .net_buf_stat(net_buf_stat), .mem_buf_stat(mem_buf_stat),
    .mem_par_err(m_err), .msg_par_err(g_err), .node_addr_strap(strap),
    .boot_mode(boot_mode), .cache_locked(cache_locked), .periph_mode(periph_mode),
    .node_addr(node_addr), .scan_ic_wr(ic_wr), .scan_ic_addr(ic_addr),
    .scan_ic_data(ic_data), .scan_dbg(dbg), .scan_cap(scan_cap), .scan_view(scan_view),
    .icache_rdata(icache_rdata), .icache_raddr(icache_raddr), .irq(irq));
  nepu_far_model u_far (.clock(clock), .net_rx_new(rx_new), .net_rx_word0(rx_w0),
    .net_tx_room(tx_room), .mem_par_err(m_err), .msg_par_err(g_err), .scan_ic_wr(ic_wr),
    .scan_ic_addr(ic_addr), .scan_ic_data(ic_data), .scan_dbg(dbg));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask
  // fault expected only for a user access strictly below the boundary
  task automatic acc(input logic [31:0] a, input logic k);
    logic f;
    f = !k && a < bnd;
    pf = pf | f;
    @(posedge clock);
    cpu_acc <= 1'b1;
    cpu_addr <= a;
    cpu_kernel <= k;
    @(posedge clock);
    cpu_acc <= 1'b0;
    #1;
    chk("acc_fault", {31'h0, f}, {31'h0, acc_fault});
    chk("acc_grant", {31'h0, !f}, {31'h0, acc_grant});
  endtask
  task automatic wait_ev(input logic [2:0] c, input logic [31:0] x);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (ev_take !== 1'b1 && i < 200);
    chk("ev_cause", {29'h0, c}, {29'h0, ev_cause});
    chk("ev_vector", x, ev_vector);
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    chk("boot", 32'h7, {29'h0, boot_mode, cache_locked, periph_mode});
    chk("node_addr", {16'h0, strap}, {16'h0, node_addr});
    rd(`NEPU_A_ERRS, d);
    chk("errs", 32'h0, d);
    rd(`NEPU_A_NODE_ADDR, d);
    chk("node_reg", {16'h0, strap}, d);
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {reg_wr, reg_rd, cpu_acc, cpu_kernel, cpu_can_take, scan_cap} = 6'h0;
    {reg_addr, reg_wdata, cpu_addr, cpu_pc, net_buf_stat, mem_buf_stat} = 112'h0;
    icache_raddr = 8'h0;
    rnd = 32'h3F;
    strap = 16'hA5C3;
    srst = 1'b1;
    clk_en = 1'b1;
    pf = 1'b0;
    do_reset();
    bnd = `NEPU_BOUND_RST;
    rd(`NEPU_A_BOUND, d);
    chk("bound", bnd, d);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      if (i == 8) begin
        bnd = {16'h0, rnd[15:8] | 8'h01, rnd[7:0]};
        wr(`NEPU_A_BOUND, bnd);
      end
      acc(i[2] ? bnd - 1 + i[0] : (i[1] ? rnd % bnd : rnd), i[3] ^ i[0]);
    end
    rd(`NEPU_A_STATUS, d);
    chk("prot_status", {28'h0, pf, 3'h0}, d);
    rnd = lfsr(rnd);
    ia = rnd[7:0];
    u_far.ic_write(ia, rnd);
    icache_raddr <= ia;
    repeat (2) @(posedge clock);
    #1;
    chk("icache", rnd, icache_rdata);
    rnd = lfsr(rnd);
    wr(`NEPU_A_PROF, rnd);
    cpu_pc <= ~rnd;
    net_buf_stat <= rnd[7:0];
    mem_buf_stat <= rnd[15:8];
    u_far.par_err();
    scan_cap <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk("view_prof", rnd, scan_view[31:0]);
    chk("view_pc", ~rnd, scan_view[63:32]);
    chk("view_bufs", {16'h0, rnd[7:0], rnd[15:8]}, {16'h0, scan_view[79:64]});
    chk("view_errs", 32'h3, {24'h0, scan_view[87:80]});
    scan_cap <= 1'b0;
    strap = rnd[31:16];
    @(posedge clock);
    do_reset();
    // several events held back, then taken in priority order
    wr(`NEPU_A_ENABLE, 32'h1F);
    wr(`NEPU_A_CTRL, 32'h1);
    w0 = lfsr(rnd);
    u_far.send_msg(w0);
    u_far.force_dbg();
    repeat (10) @(posedge clock);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    cpu_can_take <= 1'b1;
    wait_ev(3'h1, `NEPU_DBG_VEC_RST);
    wait_ev(3'h3, w0);
    rd(`NEPU_A_STATUS, d);
    chk("ev_status", 32'h11, d);
    wr(`NEPU_A_CLEAR, 32'h1F);
    rd(`NEPU_A_STATUS, d);
    chk("status", 32'h0, d);
    chk("irq", 32'h0, {31'h0, irq});
    v = lfsr(w0);
    wr(`NEPU_A_TMR_VEC, v);
    rd(`NEPU_A_TIMER, d);
    // timer moves on two enabled edges before the freeze and one after it
    @(posedge clock);
    clk_en <= 1'b0;
    repeat (8) @(posedge clock);
    clk_en <= 1'b1;
    rd(`NEPU_A_TIMER, t);
    chk("timer", d + 32'h3, t);
    wr(`NEPU_A_TIMEOUT, t + 32'h28);
    wait_ev(3'h4, v);
    v = lfsr(v);
    wr(`NEPU_A_DEP_VEC, v);
    wr(`NEPU_A_CTRL, 32'h3);
    chk("boot", 32'h0, {29'h0, boot_mode, cache_locked, periph_mode});
    u_far.set_room(1'b1);
    wait_ev(3'h5, v);
    conclude();
  end
endmodule
